// File: logic/loop_test_pkg.sv
// constants and types for the loopback and pattern test controller
package loop_test_pkg;
  localparam int unsigned clock_hz = 50000000;
  // remote loop guard time after link-up, in seconds
  localparam int unsigned guard_time_s = 45;
  localparam longint unsigned guard_cycles_l = longint'(guard_time_s) * longint'(clock_hz);
  // error injection interval, in milliseconds
  localparam int unsigned inject_period_ms = 1000;
  localparam longint unsigned inject_cycles_l = longint'(inject_period_ms) * longint'(clock_hz) / 1000;
  // pattern shift register length and feedback taps
  localparam int unsigned prbs_len = 9;
  localparam int unsigned prbs_tap_a = 5;
  localparam int unsigned prbs_tap_b = 9;
  localparam logic [8:0] prbs_seed = 9'h1ff;
  // error flash stretch so a single error is visible, in ms
  localparam int unsigned flash_time_ms = 50;
  localparam longint unsigned flash_cycles_l = longint'(flash_time_ms) * longint'(clock_hz) / 1000;
  // wishbone register offsets
  localparam logic [3:0] ctrl_off = 4'h0;
  localparam logic [3:0] status_off = 4'h4;
  localparam logic [3:0] errcnt_off = 4'h8;
  // control register field positions
  localparam int unsigned ctrl_local_bit = 0;
  localparam int unsigned ctrl_remote_bit = 1;
  localparam int unsigned ctrl_pat_bit = 2;
  localparam int unsigned ctrl_inj_bit = 3;
  localparam logic [3:0] ctrl_reset = 4'h0;
  // loop state
  typedef enum logic [2:0] {
    loop_off_s = 3'b001,
    loop_local_s = 3'b010,
    loop_remote_s = 3'b100
  } loop_state_t;
endpackage : loop_test_pkg

// File: logic/loop_test_ctrl.sv
// loopback, pattern test and front-panel indicator controller
//
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module loop_test_ctrl #(
  parameter longint unsigned guard_cycles = loop_test_pkg::guard_cycles_l,
  parameter longint unsigned inject_cycles = loop_test_pkg::inject_cycles_l,
  parameter longint unsigned flash_cycles = loop_test_pkg::flash_cycles_l
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // terminal side
  input wire logic term_txd_i,
  input wire logic term_dtr_i,
  input wire logic term_local_loop_i,
  input wire logic term_remote_loop_i,
  output logic term_rxd_o,
  output logic term_cts_o,
  // line side
  input wire logic line_rxd_i,
  input wire logic line_carrier_i,
  input wire logic line_data_mode_i,
  input wire logic remote_in_test_i,
  output logic line_txd_o,
  output logic remote_loop_req_o,
  // panel
  input wire logic panel_local_i,
  input wire logic panel_remote_i,
  input wire logic panel_pat_up_i,
  input wire logic panel_pat_down_i,
  input wire logic power_good_i,
  // indicators: green_o high means green, low means yellow
  output logic led_power_o,
  output logic led_txd_green_o,
  output logic led_rxd_green_o,
  output logic led_cts_green_o,
  output logic led_carrier_green_o,
  output logic led_dtr_green_o,
  output logic led_error_red_o,
  output logic led_test_yellow_o,
  output logic led_no_signal_red_o,
  output logic bit_error_o
);
  loop_test_pkg::loop_state_t loop_state;
  logic [3:0] ctrl;
  logic [15:0] err_count;
  logic [35:0] guard_cnt;
  logic guard_done;
  logic [35:0] inj_cnt;
  logic inj_pulse;
  logic [8:0] gen_sr;
  logic [8:0] chk_sr;
  logic [35:0] flash_cnt;
  logic local_req;
  logic remote_req;
  logic pat_on;
  logic inj_on;
  logic gen_bit;
  logic tx_bit;
  logic rx_bit;
  logic chk_err;
  logic bus_req;

  // loop requests merged from panel, terminal and management
  assign local_req = panel_local_i | term_local_loop_i | ctrl[loop_test_pkg::ctrl_local_bit];
  assign remote_req = (panel_remote_i | term_remote_loop_i | ctrl[loop_test_pkg::ctrl_remote_bit])
                      & line_data_mode_i & guard_done;
  // pattern test: up is plain, down injects; plain tests need data mode or a local loop
  assign inj_on = panel_pat_down_i | ctrl[loop_test_pkg::ctrl_inj_bit];
  assign pat_on = inj_on | ((panel_pat_up_i | ctrl[loop_test_pkg::ctrl_pat_bit])
                  & (line_data_mode_i | loop_state == loop_test_pkg::loop_local_s));

  // guard timer counts from link establishment
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !line_data_mode_i) begin
      guard_cnt <= 36'h0;
      guard_done <= 1'b0;
    end else if (!guard_done) begin
      guard_cnt <= guard_cnt + 36'h1;
      guard_done <= (guard_cnt + 36'h1 >= guard_cycles[35:0]);
    end
  end

  // loop state: the active loop holds until its own request drops
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      loop_state <= loop_test_pkg::loop_off_s;
    end else begin
      case (loop_state)
        loop_test_pkg::loop_off_s: begin
          if (local_req) begin
            loop_state <= loop_test_pkg::loop_local_s;
          end else if (remote_req) begin
            loop_state <= loop_test_pkg::loop_remote_s;
          end
        end
        loop_test_pkg::loop_local_s: begin
          if (!local_req) begin
            loop_state <= loop_test_pkg::loop_off_s;
          end
        end
        loop_test_pkg::loop_remote_s: begin
          // link loss also drops the remote loop
          if (!remote_req) begin
            loop_state <= loop_test_pkg::loop_off_s;
          end
        end
        default: loop_state <= loop_test_pkg::loop_off_s;
      endcase
    end
  end

  // once-per-second injection strobe
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !inj_on) begin
      inj_cnt <= 36'h0;
      inj_pulse <= 1'b0;
    end else if (inj_cnt + 36'h1 >= inject_cycles[35:0]) begin
      inj_cnt <= 36'h0;
      inj_pulse <= 1'b1;
    end else begin
      inj_cnt <= inj_cnt + 36'h1;
      inj_pulse <= 1'b0;
    end
  end

  // generator: one bit per clock, taps five and nine
  assign gen_bit = gen_sr[loop_test_pkg::prbs_tap_a - 1] ^ gen_sr[loop_test_pkg::prbs_tap_b - 1];
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !pat_on) begin
      gen_sr <= loop_test_pkg::prbs_seed;
    end else begin
      gen_sr <= {gen_sr[7:0], gen_bit};
    end
  end

  // transmitted bit: pattern (with injected flip) replaces terminal data
  assign tx_bit = pat_on ? (gen_bit ^ inj_pulse) : term_txd_i;
  // received bit: local loop takes our own transmitter, else the line
  assign rx_bit = (loop_state == loop_test_pkg::loop_local_s) ? tx_bit : line_rxd_i;

  // self-synchronising checker: shift in received bits, compare prediction
  assign chk_err = pat_on & (rx_bit != (chk_sr[loop_test_pkg::prbs_tap_a - 1] ^
                   chk_sr[loop_test_pkg::prbs_tap_b - 1]));
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      chk_sr <= loop_test_pkg::prbs_seed;
      bit_error_o <= 1'b0;
    end else begin
      chk_sr <= {chk_sr[7:0], rx_bit};
      bit_error_o <= chk_err;
    end
  end

  // data paths; in local loop line data is returned to the line
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      term_rxd_o <= 1'b1;
      line_txd_o <= 1'b1;
      remote_loop_req_o <= 1'b0;
      term_cts_o <= 1'b0;
    end else begin
      term_rxd_o <= pat_on ? 1'b1 : rx_bit;
      line_txd_o <= (loop_state == loop_test_pkg::loop_local_s) ? line_rxd_i : tx_bit;
      remote_loop_req_o <= (loop_state == loop_test_pkg::loop_remote_s);
      term_cts_o <= line_data_mode_i & term_dtr_i;
    end
  end

  // error flash stretcher, retriggered by each detected error
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      flash_cnt <= 36'h0;
    end else if (bit_error_o) begin
      flash_cnt <= flash_cycles[35:0];
    end else if (flash_cnt != 36'h0) begin
      flash_cnt <= flash_cnt - 36'h1;
    end
  end

  // indicators, all registered
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      led_power_o <= 1'b0;
      led_txd_green_o <= 1'b0;
      led_rxd_green_o <= 1'b0;
      led_cts_green_o <= 1'b0;
      led_carrier_green_o <= 1'b0;
      led_dtr_green_o <= 1'b0;
      led_error_red_o <= 1'b0;
      led_test_yellow_o <= 1'b0;
      led_no_signal_red_o <= 1'b1;
    end else begin
      led_power_o <= power_good_i;
      led_txd_green_o <= ~term_txd_i;
      led_rxd_green_o <= ~term_rxd_o;
      led_cts_green_o <= term_cts_o;
      led_carrier_green_o <= line_carrier_i;
      led_dtr_green_o <= term_dtr_i;
      // without a pattern test, lost carrier in data mode hints at errors
      led_error_red_o <= pat_on ? (flash_cnt != 36'h0) : (line_data_mode_i & ~line_carrier_i);
      led_test_yellow_o <= (loop_state != loop_test_pkg::loop_off_s) | pat_on | remote_in_test_i;
      led_no_signal_red_o <= ~line_data_mode_i;
    end
  end

  // wishbone slave: one-cycle ack, unmapped reads give zero
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl <= loop_test_pkg::ctrl_reset;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && wb_we_i && wb_adr_i == loop_test_pkg::ctrl_off && wb_sel_i[0]) begin
        ctrl <= wb_dat_i[3:0];
      end
      case (wb_adr_i)
        loop_test_pkg::ctrl_off: wb_dat_o <= {28'h0, ctrl};
        loop_test_pkg::status_off: wb_dat_o <= {25'h0, guard_done, pat_on, inj_on, line_data_mode_i, loop_state};
        loop_test_pkg::errcnt_off: wb_dat_o <= {16'h0, err_count};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // saturating error counter, cleared by a write to its offset unless an error is counted in that cycle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      err_count <= 16'h0;
    end else if (bit_error_o && err_count != 16'hffff) begin
      err_count <= err_count + 16'h1;
    end else if (bus_req && wb_we_i && wb_adr_i == loop_test_pkg::errcnt_off) begin
      err_count <= 16'h0;
    end
  end

  // remote loop only once the guard time after link-up has run out
  property p_guard;
    @(posedge clock_i) disable iff (!rst_n_i)
    !guard_done |=> loop_state != loop_test_pkg::loop_remote_s;
  endproperty
  a_guard: assert property (p_guard) else $error("remote loop before guard");

  // an active local loop is not taken over while still requested
  property p_excl;
    @(posedge clock_i) disable iff (!rst_n_i)
    loop_state == loop_test_pkg::loop_local_s && local_req |=> loop_state == loop_test_pkg::loop_local_s;
  endproperty
  a_excl: assert property (p_excl) else $error("local loop lost while requested");

  // local loop echoes terminal data one cycle later
  property p_local_echo;
    @(posedge clock_i) disable iff (!rst_n_i)
    loop_state == loop_test_pkg::loop_local_s && !pat_on |=> term_rxd_o == $past(term_txd_i);
  endproperty
  a_local_echo: assert property (p_local_echo) else $error("local loop echo wrong");

  // no link means the no-signal lamp is on
  property p_ns;
    @(posedge clock_i) disable iff (!rst_n_i)
    !line_data_mode_i |=> led_no_signal_red_o;
  endproperty
  a_ns: assert property (p_ns) else $error("no signal not shown");

  // any loop lights the test-mode lamp
  property p_tm;
    @(posedge clock_i) disable iff (!rst_n_i)
    loop_state != loop_test_pkg::loop_off_s |=> led_test_yellow_o;
  endproperty
  a_tm: assert property (p_tm) else $error("test mode not shown");

  // a detected error during a pattern test shows on the error lamp
  property p_flash;
    @(posedge clock_i) disable iff (!rst_n_i)
    bit_error_o && pat_on ##1 pat_on |=> led_error_red_o;
  endproperty
  a_flash: assert property (p_flash) else $error("error not flashed");

  // transmit lamp follows the inverted terminal data level
  property p_txd;
    @(posedge clock_i) disable iff (!rst_n_i)
    1'b1 |=> led_txd_green_o == !$past(term_txd_i);
  endproperty
  a_txd: assert property (p_txd) else $error("txd colour wrong");

  // a terminal local request from idle starts the local loop
  property p_local_req;
    @(posedge clock_i) disable iff (!rst_n_i)
    loop_state == loop_test_pkg::loop_off_s && term_local_loop_i |=> loop_state == loop_test_pkg::loop_local_s;
  endproperty
  a_local_req: assert property (p_local_req) else $error("local loop request ignored");

  // clear-to-send lamp mirrors our own clear-to-send output
  property p_cts;
    @(posedge clock_i) disable iff (!rst_n_i)
    1'b1 |=> led_cts_green_o == $past(term_cts_o);
  endproperty
  a_cts: assert property (p_cts) else $error("cts colour wrong");

  // terminal-ready lamp follows the terminal's ready input
  property p_dtr;
    @(posedge clock_i) disable iff (!rst_n_i)
    1'b1 |=> led_dtr_green_o == $past(term_dtr_i);
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr colour wrong");

  // without data mode no remote loop may stand
  property p_remote_link;
    @(posedge clock_i) disable iff (!rst_n_i)
    !line_data_mode_i |=> loop_state != loop_test_pkg::loop_remote_s;
  endproperty
  a_remote_link: assert property (p_remote_link) else $error("remote loop without link");
endmodule : loop_test_ctrl
`default_nettype wire

// File: verif/far_end_model.sv
// behavioural far-end line driver: link state, carrier and remote loop return path
`timescale 1ns/100ps
`default_nettype none
module far_end_model (
  input wire logic clock_i,
  input wire logic link_up_i,
  input wire logic far_data_i,
  input wire logic far_test_i,
  input wire logic loop_req_i,
  input wire logic line_txd_i,
  output logic line_rxd_o,
  output logic carrier_o,
  output logic data_mode_o,
  output logic in_test_o
);
  // one-cycle turnaround; outside the loop it sends bench data, never a pattern of its own
  always_ff @(posedge clock_i) begin
    line_rxd_o <= (loop_req_i && link_up_i) ? line_txd_i : far_data_i;
    carrier_o <= link_up_i;
    data_mode_o <= link_up_i;
    in_test_o <= far_test_i;
  end
endmodule : far_end_model
`default_nettype wire

// File: verif/tb_loop_test_ctrl.sv
// self-checking bench for the loopback and pattern test controller
`timescale 1ns/100ps
`default_nettype none
module tb_loop_test_ctrl;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic txd = 1'b1, dtr = 1'b0, tlocal = 1'b0, tremote = 1'b0, p_local = 1'b0, p_remote = 1'b0;
  logic pat_up = 1'b0, pat_down = 1'b0, pgood = 1'b1, link = 1'b0, far_data = 1'b1, far_test = 1'b0;
  logic ack, rxd, cts, ltxd, rreq, l_pw, l_tx, l_rx, l_cts, l_cd, l_dtr, l_er, l_tm, l_ns, berr;
  logic lrxd, carrier, dmode, rtest;
  logic seen_red = 1'b0;
  int failures = 0, samples_checked = 0, errs = 0;

  // short counts keep the guard and injection phases within a few hundred cycles
  loop_test_ctrl #(.guard_cycles(64'd100), .inject_cycles(64'd50), .flash_cycles(64'd10)) loop_test_ctrl_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .term_txd_i(txd), .term_dtr_i(dtr),
    .term_local_loop_i(tlocal), .term_remote_loop_i(tremote), .term_rxd_o(rxd), .term_cts_o(cts),
    .line_rxd_i(lrxd), .line_carrier_i(carrier), .line_data_mode_i(dmode), .remote_in_test_i(rtest),
    .line_txd_o(ltxd), .remote_loop_req_o(rreq), .panel_local_i(p_local), .panel_remote_i(p_remote),
    .panel_pat_up_i(pat_up), .panel_pat_down_i(pat_down), .power_good_i(pgood), .led_power_o(l_pw),
    .led_txd_green_o(l_tx), .led_rxd_green_o(l_rx), .led_cts_green_o(l_cts), .led_carrier_green_o(l_cd),
    .led_dtr_green_o(l_dtr), .led_error_red_o(l_er), .led_test_yellow_o(l_tm), .led_no_signal_red_o(l_ns),
    .bit_error_o(berr));

  far_end_model far_end_model_i (.clock_i(clock_i), .link_up_i(link), .far_data_i(far_data),
    .far_test_i(far_test), .loop_req_i(rreq), .line_txd_i(ltxd), .line_rxd_o(lrxd), .carrier_o(carrier),
    .data_mode_o(dmode), .in_test_o(rtest));

  initial begin
    forever #10 clock_i = ~clock_i;
  end

  // pre-edge sampling, so each one-cycle pulse is counted once
  always @(posedge clock_i) begin
    if (rst_n_i === 1'b1 && berr === 1'b1) errs++;
    if (rst_n_i === 1'b1 && l_er === 1'b1) seen_red = 1'b1;
  end

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task chk1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask : chk1

  task tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick

  // classic cycle: hold everything until ack is sampled high, then release
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; wdat <= d;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack === 1'b1) begin
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    end else begin
      failures++;
      report_and_stop();
    end
  endtask : wb

  task st(input logic [31:0] exp);
    wb(1'b0, loop_test_pkg::status_off, 32'h0);
    check(q & 32'h0f, exp);
  endtask : st

  // loop request sources: 0..2 local (panel, terminal, register), 3..5 remote
  task src(input int k, input logic v);
    case (k)
      0: p_local <= v;
      1: tlocal <= v;
      2: wb(1'b1, loop_test_pkg::ctrl_off, 32'(v) << loop_test_pkg::ctrl_local_bit);
      3: p_remote <= v;
      4: tremote <= v;
      default: wb(1'b1, loop_test_pkg::ctrl_off, 32'(v) << loop_test_pkg::ctrl_remote_bit);
    endcase
  endtask : src

  initial begin
    tick(6);
    rst_n_i <= 1'b1;
    tick(2);
    chk1(l_ns, 1'b1);
    chk1(l_pw, 1'b1);
    chk1(l_tx, 1'b0);
    wb(1'b0, loop_test_pkg::ctrl_off, 32'h0);
    check(q, 32'h0);
    wb(1'b0, 4'hc, 32'h0);
    check(q, 32'h0);
    txd <= 1'b0; link <= 1'b1; dtr <= 1'b1; far_data <= 1'b0;
    tick(4);
    chk1(l_tx, 1'b1);
    chk1(l_rx, 1'b1);
    chk1(cts, 1'b1);
    chk1(l_cts, 1'b1);
    chk1(l_cd, 1'b1);
    chk1(l_dtr, 1'b1);
    chk1(l_ns, 1'b0);
    chk1(l_tm, 1'b0);
    for (int k = 0; k < 3; k++) begin
      src(k, 1'b1);
      tick(4);
      st(32'ha);
      chk1(l_tm, 1'b1);
      txd <= k[0];
      tick(4);
      chk1(rxd, k[0]);
      far_data <= ~k[0];
      tick(4);
      chk1(ltxd, ~k[0]);
      src(k, 1'b0);
      tick(4);
      st(32'h9);
    end
    src(0, 1'b1);
    tick(4);
    src(4, 1'b1);
    tick(4);
    st(32'ha);
    src(0, 1'b0);
    src(4, 1'b0);
    tick(4);
    // fresh link-up restarts the guard time
    link <= 1'b0;
    tick(4);
    link <= 1'b1;
    src(4, 1'b1);
    tick(20);
    st(32'h9);
    tick(100);
    st(32'hc);
    chk1(rreq, 1'b1);
    txd <= 1'b0;
    tick(6);
    chk1(rxd, 1'b0);
    txd <= 1'b1;
    tick(6);
    chk1(rxd, 1'b1);
    chk1(l_tm, 1'b1);
    src(0, 1'b1);
    tick(4);
    st(32'hc);
    src(0, 1'b0);
    src(4, 1'b0);
    tick(4);
    st(32'h9);
    for (int k = 3; k < 6; k++) begin
      src(k, 1'b1);
      tick(4);
      st(32'hc);
      src(k, 1'b0);
      tick(4);
      st(32'h9);
    end
    src(3, 1'b1);
    pat_up <= 1'b1;
    // loop latency plus nine bits of checker sync give start-up errors; let them pass
    tick(20);
    wb(1'b1, loop_test_pkg::errcnt_off, 32'h0);
    tick(200);
    wb(1'b0, loop_test_pkg::errcnt_off, 32'h0);
    check(q, 32'h0);
    wb(1'b0, loop_test_pkg::status_off, 32'h0);
    check(q & 32'h20, 32'h20);
    chk1(l_er, 1'b0);
    pat_up <= 1'b0;
    pat_down <= 1'b1;
    tick(4);
    wb(1'b1, loop_test_pkg::errcnt_off, 32'h0);
    errs = 0;
    seen_red = 1'b0;
    tick(250);
    pat_down <= 1'b0;
    tick(4);
    wb(1'b0, loop_test_pkg::errcnt_off, 32'h0);
    // about five flips; a self-synchronising checker reports each flip three times
    chk1(q >= 10 && q <= 18, 1'b1);
    chk1(errs >= 10 && errs <= 18, 1'b1);
    chk1(seen_red, 1'b1);
    src(3, 1'b0);
    link <= 1'b0;
    pat_up <= 1'b1;
    src(4, 1'b1);
    tick(6);
    wb(1'b0, loop_test_pkg::status_off, 32'h0);
    check(q & 32'h2f, 32'h01);
    chk1(l_ns, 1'b1);
    far_test <= 1'b1;
    tick(4);
    chk1(l_tm, 1'b1);
    report_and_stop();
  end
endmodule : tb_loop_test_ctrl
`default_nettype wire
